/* File: src/cpvp_pkg.sv */
//-----------------------------------------------------------------------
// Purpose: constants and types of the cell and pack voltage protection
// Assumes: 50 MHz clock, APB register access, one-second timer tick
// Notes:   protection index 0 cell over, 1 pack over, 2 cell under
//-----------------------------------------------------------------------
package cpvp_pkg;

    //-------------------------------------------------------------------
    // timing
    //-------------------------------------------------------------------
    localparam int CPVP_CLK_HZ = 50_000_000;
    localparam int CPVP_TICK_MS = 1000;
    localparam int CPVP_TICK_CYCLES = CPVP_CLK_HZ / 1000 * CPVP_TICK_MS;

    //-------------------------------------------------------------------
    // register byte offsets
    //-------------------------------------------------------------------
    localparam logic [7:0] CPVP_CTRL = 8'h00;
    localparam logic [7:0] CPVP_MEAS_CELL = 8'h04;
    localparam logic [7:0] CPVP_MEAS_PACK = 8'h08;
    localparam logic [7:0] CPVP_MEAS_IT = 8'h0C;
    localparam logic [7:0] CPVP_COV_CFG = 8'h10;
    localparam logic [7:0] CPVP_POV_CFG = 8'h14;
    localparam logic [7:0] CPVP_CUV_CFG = 8'h18;
    localparam logic [7:0] CPVP_TIME_CFG = 8'h1C;
    localparam logic [7:0] CPVP_COMP_CFG = 8'h20;
    localparam logic [7:0] CPVP_CUR_CFG = 8'h24;
    localparam logic [7:0] CPVP_CHG_CFG = 8'h28;
    localparam logic [7:0] CPVP_PRECHG = 8'h2C;
    localparam logic [7:0] CPVP_STATUS = 8'h30;
    localparam logic [7:0] CPVP_REQ = 8'h34;
    localparam logic [7:0] CPVP_IRQ_STAT = 8'h38;
    localparam logic [7:0] CPVP_IRQ_MASK = 8'h3C;

    //-------------------------------------------------------------------
    // field positions
    //-------------------------------------------------------------------
    localparam int CPVP_HI = 16;
    localparam int CPVP_ZV_LO = 0;
    localparam int CPVP_ZV_HI = 1;
    localparam int CPVP_DSG_FLAG = 2;
    localparam int CPVP_FD_CLR = 3;
    localparam int CPVP_POV_T = 8;
    localparam int CPVP_CUV_T = 16;
    localparam int CPVP_HYS = 16;
    localparam int CPVP_DELTA = 24;
    localparam int CPVP_NPROT = 3;

    //-------------------------------------------------------------------
    // reset values
    //-------------------------------------------------------------------
    localparam logic [15:0] CPVP_COV_THR_RST = 16'h10CC;
    localparam logic [15:0] CPVP_COV_REC_RST = 16'h0F3C;
    localparam logic [15:0] CPVP_POV_THR_RST = 16'h445C;
    localparam logic [15:0] CPVP_POV_REC_RST = 16'h3E80;
    localparam logic [15:0] CPVP_CUV_THR_RST = 16'h0898;
    localparam logic [15:0] CPVP_CUV_REC_RST = 16'h0BB8;
    localparam logic [7:0] CPVP_TIME_RST = 8'h02;
    localparam logic [15:0] CPVP_OT_CHG_RST = 16'h0226;
    localparam logic [7:0] CPVP_HYS_RST = 8'h64;
    localparam logic [7:0] CPVP_DELTA_RST = 8'h14;
    localparam logic [15:0] CPVP_CUR_THR_RST = 16'h0064;
    localparam logic [15:0] CPVP_CHG_I_RST = 16'h07D0;
    localparam logic [15:0] CPVP_CHG_V_RST = 16'h41A0;
    localparam logic [15:0] CPVP_PRE_I_RST = 16'h0064;

    //-------------------------------------------------------------------
    // types
    //-------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] zv_sel;
        logic discharging;
        logic [15:0] max_cell;
        logic [15:0] min_cell;
        logic [15:0] pack;
        logic [15:0] current;
        logic [15:0] temp;
    } cpvp_meas_t;

    typedef struct packed {
        logic [2:0][15:0] thr;
        logic [2:0][15:0] rec;
        logic [2:0][7:0] qtime;
        logic [15:0] ot_chg;
        logic [7:0] hys;
        logic [7:0] delta;
        logic [15:0] dsg_thr;
        logic [15:0] chg_thr;
        logic [15:0] chg_i;
        logic [15:0] chg_v;
        logic [15:0] pre_i;
    } cpvp_cfg_t;

    typedef struct packed {
        logic [18:0] rsvd;
        logic zv_fet;
        logic dsg_fet;
        logic chg_fet;
        logic discharge_inhibited_flag;
        logic fd;
        logic terminate_discharge_alarm;
        logic tca;
        logic [2:0] safety;
        logic [2:0] alert;
    } cpvp_status_t;

    typedef enum logic [1:0] {
        CPVP_IDLE,
        CPVP_PENDING,
        CPVP_LATCHED
    } cpvp_prot_st_t;

endpackage : cpvp_pkg

/* File: src/cpvp_top.sv */
//-----------------------------------------------------------------------
// Purpose: cell over, pack over and cell under voltage protection
// Assumes: firmware writes measurements over APB once per update
// Notes:   all latch and recovery decisions are taken on the one-second tick
//-----------------------------------------------------------------------
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns

module cpvp_top
    import cpvp_pkg::*;
#(
    parameter int TICK_CYCLES = CPVP_TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fet drives and interrupt
    output logic chg_fet_o,
    output logic dsg_fet_o,
    output logic zero_volt_charge_fet_o,
    output logic irq_o
);

    //-------------------------------------------------------------------
    // address decode
    //-------------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= CPVP_IRQ_MASK);
    endfunction : addr_ok

    logic wr_en;
    logic rd_done;
    logic setup;
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
    assign rd_done = psel_i && penable_i && pready_o && !pwrite_i;

    //-------------------------------------------------------------------
    // tick divider
    //-------------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 32'h1;
        if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 32'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    //-------------------------------------------------------------------
    // configuration and measurement registers
    //-------------------------------------------------------------------
    cpvp_meas_t meas;
    cpvp_meas_t next_meas;
    cpvp_cfg_t cfg;
    cpvp_cfg_t next_cfg;
    logic [31:0] irq_mask;
    logic [31:0] next_irq_mask;
    logic fd_clr;

    always_comb begin
        next_meas = meas;
        next_cfg = cfg;
        next_irq_mask = irq_mask;
        fd_clr = 1'b0;
        if (wr_en) begin
            case (paddr_i)
                CPVP_CTRL: begin
                    next_meas.zv_sel = {pwdata_i[CPVP_ZV_HI],
                                        pwdata_i[CPVP_ZV_LO]};
                    next_meas.discharging = pwdata_i[CPVP_DSG_FLAG];
                    fd_clr = pwdata_i[CPVP_FD_CLR];
                end
                CPVP_MEAS_CELL: begin
                    next_meas.max_cell = pwdata_i[15:0];
                    next_meas.min_cell = pwdata_i[31:CPVP_HI];
                end
                CPVP_MEAS_PACK: next_meas.pack = pwdata_i[15:0];
                CPVP_MEAS_IT: begin
                    next_meas.current = pwdata_i[15:0];
                    next_meas.temp = pwdata_i[31:CPVP_HI];
                end
                CPVP_COV_CFG: begin
                    next_cfg.thr[0] = pwdata_i[15:0];
                    next_cfg.rec[0] = pwdata_i[31:CPVP_HI];
                end
                CPVP_POV_CFG: begin
                    next_cfg.thr[1] = pwdata_i[15:0];
                    next_cfg.rec[1] = pwdata_i[31:CPVP_HI];
                end
                CPVP_CUV_CFG: begin
                    next_cfg.thr[2] = pwdata_i[15:0];
                    next_cfg.rec[2] = pwdata_i[31:CPVP_HI];
                end
                CPVP_TIME_CFG: begin
                    next_cfg.qtime[0] = pwdata_i[7:0];
                    next_cfg.qtime[1] = pwdata_i[CPVP_POV_T +: 8];
                    next_cfg.qtime[2] = pwdata_i[CPVP_CUV_T +: 8];
                end
                CPVP_COMP_CFG: begin
                    next_cfg.ot_chg = pwdata_i[15:0];
                    next_cfg.hys = pwdata_i[CPVP_HYS +: 8];
                    next_cfg.delta = pwdata_i[CPVP_DELTA +: 8];
                end
                CPVP_CUR_CFG: begin
                    next_cfg.dsg_thr = pwdata_i[15:0];
                    next_cfg.chg_thr = pwdata_i[31:CPVP_HI];
                end
                CPVP_CHG_CFG: begin
                    next_cfg.chg_i = pwdata_i[15:0];
                    next_cfg.chg_v = pwdata_i[31:CPVP_HI];
                end
                CPVP_PRECHG: next_cfg.pre_i = pwdata_i[15:0];
                CPVP_IRQ_MASK: next_irq_mask = {26'h0, pwdata_i[5:0]};
                default: next_irq_mask = irq_mask;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meas <= '0;
            cfg.thr <= {CPVP_CUV_THR_RST, CPVP_POV_THR_RST,
                        CPVP_COV_THR_RST};
            cfg.rec <= {CPVP_CUV_REC_RST, CPVP_POV_REC_RST,
                        CPVP_COV_REC_RST};
            cfg.qtime <= {CPVP_TIME_RST, CPVP_TIME_RST, CPVP_TIME_RST};
            cfg.ot_chg <= CPVP_OT_CHG_RST;
            cfg.hys <= CPVP_HYS_RST;
            cfg.delta <= CPVP_DELTA_RST;
            cfg.dsg_thr <= CPVP_CUR_THR_RST;
            cfg.chg_thr <= CPVP_CUR_THR_RST;
            cfg.chg_i <= CPVP_CHG_I_RST;
            cfg.chg_v <= CPVP_CHG_V_RST;
            cfg.pre_i <= CPVP_PRE_I_RST;
            irq_mask <= 32'h0;
        end else begin
            meas <= next_meas;
            cfg <= next_cfg;
            irq_mask <= next_irq_mask;
        end
    end

    //-------------------------------------------------------------------
    // fault conditions
    //-------------------------------------------------------------------
    logic signed [17:0] temp_s;
    logic signed [17:0] hot_lim;
    logic signed [17:0] cur_s;
    logic comp_on;
    logic [15:0] cov_thr_eff;
    logic [2:0] fault;
    logic [2:0] recovered;
    logic dsg_cur;
    logic chg_cur;

    assign temp_s = 18'(signed'(meas.temp));
    assign cur_s = 18'(signed'(meas.current));
    assign hot_lim = signed'({2'h0, cfg.ot_chg}) -
                     signed'({10'h0, cfg.hys});
    // compensation only while charging, hot, and with a nonzero delta
    assign comp_on = !meas.discharging && (cfg.delta != 8'h0) &&
                     (temp_s > hot_lim);
    assign cov_thr_eff = comp_on ? cfg.thr[0] - {8'h0, cfg.delta}
                                 : cfg.thr[0];
    assign fault[0] = meas.max_cell >= cov_thr_eff;
    assign fault[1] = meas.pack >= cfg.thr[1];
    assign fault[2] = meas.min_cell <= cfg.thr[2];
    assign recovered[0] = meas.max_cell <= cfg.rec[0];
    assign recovered[1] = meas.pack <= cfg.rec[1];
    assign recovered[2] = meas.min_cell >= cfg.rec[2];
    assign dsg_cur = cur_s <= -signed'({2'h0, cfg.dsg_thr});
    assign chg_cur = cur_s >= signed'({2'h0, cfg.chg_thr});

    //-------------------------------------------------------------------
    // qualification timers and latches
    //-------------------------------------------------------------------
    cpvp_prot_st_t st [CPVP_NPROT];
    cpvp_prot_st_t next_st [CPVP_NPROT];
    logic [7:0] qcnt [CPVP_NPROT];
    logic [7:0] next_qcnt [CPVP_NPROT];
    logic [2:0] ev_latch;
    logic [2:0] ev_recover;

    always_comb begin
        for (int i = 0; i < CPVP_NPROT; i++) begin
            next_st[i] = st[i];
            next_qcnt[i] = qcnt[i];
            ev_latch[i] = 1'b0;
            ev_recover[i] = 1'b0;
            if (tick) begin
                case (st[i])
                    CPVP_IDLE, CPVP_PENDING: begin
                        // zero time disables; a cleared fault restarts
                        if (fault[i] && cfg.qtime[i] != 8'h0) begin
                            if (qcnt[i] + 8'h1 >= cfg.qtime[i]) begin
                                next_st[i] = CPVP_LATCHED;
                                next_qcnt[i] = 8'h0;
                                ev_latch[i] = 1'b1;
                            end else begin
                                next_st[i] = CPVP_PENDING;
                                next_qcnt[i] = qcnt[i] + 8'h1;
                            end
                        end else begin
                            next_st[i] = CPVP_IDLE;
                            next_qcnt[i] = 8'h0;
                        end
                    end
                    CPVP_LATCHED: begin
                        if (recovered[i]) begin
                            next_st[i] = CPVP_IDLE;
                            ev_recover[i] = 1'b1;
                        end
                    end
                    default: begin
                        next_st[i] = CPVP_IDLE;
                        next_qcnt[i] = 8'h0;
                    end
                endcase
            end
        end
    end

    generate
        for (genvar g = 0; g < CPVP_NPROT; g++) begin : g_prot
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    st[g] <= CPVP_IDLE;
                    qcnt[g] <= 8'h0;
                end else begin
                    st[g] <= next_st[g];
                    qcnt[g] <= next_qcnt[g];
                end
            end
        end
    endgenerate

    //-------------------------------------------------------------------
    // flags, fets, charging requests
    //-------------------------------------------------------------------
    logic [2:0] alert;
    logic [2:0] next_lat;
    cpvp_status_t status;
    cpvp_status_t next_status;
    logic [15:0] req_i;
    logic [15:0] req_v;
    logic [15:0] next_req_i;
    logic [15:0] next_req_v;
    logic chg_off;
    logic dsg_off;

    always_comb begin
        for (int i = 0; i < CPVP_NPROT; i++) begin
            alert[i] = (next_st[i] == CPVP_PENDING);
            next_lat[i] = (next_st[i] == CPVP_LATCHED);
        end
    end

    // the body diode case: reverse current lets the fet conduct again
    assign chg_off = (next_lat[0] && !dsg_cur) ||
                     (next_lat[1] && !dsg_cur);
    assign dsg_off = next_lat[2] && !chg_cur;

    always_comb begin
        next_status = status;
        next_status.rsvd = '0;
        next_status.alert = alert;
        next_status.safety = next_lat;
        next_status.chg_fet = !chg_off;
        next_status.dsg_fet = !dsg_off;
        // latched overvoltage keeps the zero-volt fet off unless zv_sel[1] is set and cell under is latched
        next_status.zv_fet = (meas.zv_sel[0] && !(next_lat[0] || next_lat[1]))
                             || (meas.zv_sel[1] && next_lat[2]);
        next_status.tca = next_lat[0] || next_lat[1];
        next_status.terminate_discharge_alarm = next_lat[2];
        next_status.discharge_inhibited_flag = next_lat[2];
        // fully discharged stays until software clears it; set wins
        next_status.fd = (status.fd && !fd_clr) || ev_latch[2];
        next_req_v = cfg.chg_v;
        next_req_i = cfg.chg_i;
        if (next_lat[2]) begin
            next_req_i = cfg.pre_i;
        end
        if (next_lat[0] || next_lat[1]) begin
            next_req_i = 16'h0;
            next_req_v = 16'h0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status <= '0;
            req_i <= 16'h0;
            req_v <= 16'h0;
        end else begin
            status <= next_status;
            req_i <= next_req_i;
            req_v <= next_req_v;
        end
    end

    //-------------------------------------------------------------------
    // interrupts: sticky events, cleared by reading
    //-------------------------------------------------------------------
    logic [5:0] irq_stat;
    logic [5:0] next_irq_stat;
    logic next_irq;

    always_comb begin
        next_irq_stat = irq_stat;
        if (rd_done && paddr_i == CPVP_IRQ_STAT) begin
            next_irq_stat = 6'h0;
        end
        next_irq_stat = next_irq_stat | {ev_recover, ev_latch};
        next_irq = |(next_irq_stat & irq_mask[5:0]);
    end

    //-------------------------------------------------------------------
    // apb answer, registered so every output leaves a flop
    //-------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    always_comb begin
        case (paddr_i)
            CPVP_CTRL: rd_mux = {29'h0, meas.discharging, meas.zv_sel};
            CPVP_MEAS_CELL: rd_mux = {meas.min_cell, meas.max_cell};
            CPVP_MEAS_PACK: rd_mux = {16'h0, meas.pack};
            CPVP_MEAS_IT: rd_mux = {meas.temp, meas.current};
            CPVP_COV_CFG: rd_mux = {cfg.rec[0], cfg.thr[0]};
            CPVP_POV_CFG: rd_mux = {cfg.rec[1], cfg.thr[1]};
            CPVP_CUV_CFG: rd_mux = {cfg.rec[2], cfg.thr[2]};
            CPVP_TIME_CFG: rd_mux = {8'h0, cfg.qtime[2], cfg.qtime[1],
                                     cfg.qtime[0]};
            CPVP_COMP_CFG: rd_mux = {cfg.delta, cfg.hys, cfg.ot_chg};
            CPVP_CUR_CFG: rd_mux = {cfg.chg_thr, cfg.dsg_thr};
            CPVP_CHG_CFG: rd_mux = {cfg.chg_v, cfg.chg_i};
            CPVP_PRECHG: rd_mux = {16'h0, cfg.pre_i};
            CPVP_STATUS: rd_mux = status;
            CPVP_REQ: rd_mux = {req_v, req_i};
            CPVP_IRQ_STAT: rd_mux = {26'h0, irq_stat};
            CPVP_IRQ_MASK: rd_mux = irq_mask;
            default: rd_mux = 32'h0;
        endcase
        next_pready = setup;
        next_pslverr = setup && !addr_ok(paddr_i);
        next_prdata = (setup && !pwrite_i) ? rd_mux : 32'h0;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat <= 6'h0;
            irq_o <= 1'b0;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            chg_fet_o <= 1'b0;
            dsg_fet_o <= 1'b0;
            zero_volt_charge_fet_o <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_o <= next_irq;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            chg_fet_o <= next_status.chg_fet;
            dsg_fet_o <= next_status.dsg_fet;
            zero_volt_charge_fet_o <= next_status.zv_fet;
        end
    end

endmodule : cpvp_top

/* File: test/cpvp_top_sva.sv */
// ---------------------------------------------------------------
// Purpose: bus and fet timing checks at the top ports
// Assumes: zero wait state slave, registered answers
// Notes:   bound into every instance of the top module
// ---------------------------------------------------------------
`timescale 1ns/1ns

module cpvp_top_sva
    import cpvp_pkg::*;
(
    // clock, reset and bus
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // fet drives
    input wire logic chg_fet_o,
    input wire logic dsg_fet_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_cause: assert property (pready_o |->
        $past(psel_i) && !$past(penable_i))
        else $error("ready without setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    a_err_bad: assert property (psel_i && !penable_i && (paddr_i[1:0] != 2'h0
        || paddr_i > CPVP_IRQ_MASK) |=> pslverr_o && pready_o)
        else $error("bad address accepted");
    a_err_good: assert property (psel_i && !penable_i && paddr_i[1:0] == 2'h0
        && paddr_i <= CPVP_IRQ_MASK |=> !pslverr_o)
        else $error("good address refused");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_fets_release: assert property (
        $rose(rstn_i) |=> chg_fet_o && dsg_fet_o)
        else $error("fets off after reset");
endmodule : cpvp_top_sva

bind cpvp_top cpvp_top_sva u_sva (.*);

/* File: test/cpvp_fet_model.sv */
// Purpose: charge and discharge paths through the pack fets
// Assumes: each fet has a body diode
// Notes:   the zero volt fet bypasses the charge fet
`timescale 1ns/1ns

module cpvp_fet_model (
    // gates
    input wire logic chg_i,
    input wire logic dsg_i,
    input wire logic zv_i,
    // paths
    output logic chg_on_o,
    output logic dsg_on_o
);
    // an off fet blocks its path; the diode is not modelled here
    assign chg_on_o = chg_i || zv_i;
    assign dsg_on_o = dsg_i;
endmodule : cpvp_fet_model

/* File: test/cpvp_top_bench.sv */
// Purpose: register level bench of the voltage protection
// Assumes: short tick of TK clocks
// Notes:   checks sit a few clocks after a tick, at phase 8 of TK
`timescale 1ns/1ns

module cpvp_top_bench;
    import cpvp_pkg::*;
    localparam int TK = 40;
    logic ref_clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic psel_i = 1'h0;
    logic penable_i = 1'h0;
    logic pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, chg_fet_o, dsg_fet_o, irq_o, er;
    logic zero_volt_charge_fet_o, chg_on, dsg_on;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    cpvp_top #(.TICK_CYCLES(TK)) u_dut (.*);
    cpvp_fet_model u_fet (.chg_i(chg_fet_o), .dsg_i(dsg_fet_o),
        .zv_i(zero_volt_charge_fet_o), .chg_on_o(chg_on), .dsg_on_o(dsg_on));
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    task automatic ck(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask : ck
    task automatic xf(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
        psel_i <= 1'h1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'h1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'h1) @(posedge ref_clk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge ref_clk_i);
    endtask : xf
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        xf(1'h1, a, d);
    endtask : w
    task automatic st(input logic [31:0] e);
        xf(1'h0, CPVP_STATUS, 32'h0);
        ck("status", rd, e);
    endtask : st
    // waiting to a fixed phase keeps every check clear of a tick
    task automatic sy;
        @(posedge ref_clk_i);
        while (cyc % TK != 8) @(posedge ref_clk_i);
    endtask : sy
    task automatic give_verdict;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'h1;
        w(CPVP_CTRL, 32'h7);
        w(CPVP_MEAS_CELL, 32'h0DAC0DAC);
        w(CPVP_MEAS_PACK, 32'h2EE0);
        w(CPVP_MEAS_IT, 32'h00FA0000);
        w(CPVP_IRQ_MASK, 32'h3F);
        xf(1'h0, CPVP_COV_CFG, 32'h0);
        ck("cov cfg", rd, 32'h0F3C10CC);
        xf(1'h0, 8'h40, 32'h0);
        ck("unmapped", rd, 32'h0);
        ck("unmapped err", er, 32'h1);
        w(CPVP_MEAS_CELL, 32'h0DAC10CC);
        sy();
        st(32'h1C01);
        w(CPVP_MEAS_CELL, 32'h0DAC10CB);
        sy();
        st(32'h1C00);
        w(CPVP_MEAS_CELL, 32'h0DAC10CC);
        sy();
        st(32'h1C01);
        sy();
        st(32'h0848);
        ck("chg path", chg_on, 32'h0);
        ck("zv fet", zero_volt_charge_fet_o, 32'h0);
        xf(1'h0, CPVP_REQ, 32'h0);
        ck("req", rd, 32'h0);
        ck("irq", irq_o, 32'h1);
        xf(1'h0, CPVP_IRQ_STAT, 32'h0);
        ck("irq stat", rd, 32'h1);
        @(posedge ref_clk_i);
        ck("irq", irq_o, 32'h0);
        w(CPVP_MEAS_IT, 32'h00FAFF9C);
        @(posedge ref_clk_i);
        ck("chg fet", chg_fet_o, 32'h1);
        w(CPVP_MEAS_IT, 32'h00FAFF9D);
        @(posedge ref_clk_i);
        ck("chg fet", chg_fet_o, 32'h0);
        w(CPVP_MEAS_CELL, 32'h0DAC0F3D);
        sy();
        st(32'h0848);
        w(CPVP_MEAS_CELL, 32'h0DAC0F3C);
        sy();
        st(32'h1C00);
        xf(1'h0, CPVP_REQ, 32'h0);
        ck("req", rd, 32'h41A007D0);
        w(CPVP_CTRL, 32'h2);
        w(CPVP_MEAS_IT, 32'h01C30000);
        w(CPVP_MEAS_CELL, 32'h0DAC10B8);
        sy();
        st(32'h0C01);
        w(CPVP_MEAS_IT, 32'h01C20000);
        sy();
        st(32'h0C00);
        w(CPVP_MEAS_IT, 32'h01C30000);
        w(CPVP_COMP_CFG, 32'h00640226);
        sy();
        st(32'h0C00);
        w(CPVP_MEAS_CELL, 32'h0DAC0DAC);
        w(CPVP_IRQ_MASK, 32'h0);
        w(CPVP_TIME_CFG, 32'h00020002);
        w(CPVP_MEAS_PACK, 32'h445C);
        sy();
        sy();
        st(32'h0C00);
        w(CPVP_TIME_CFG, 32'h00020202);
        sy();
        st(32'h0C02);
        w(CPVP_TIME_CFG, 32'h00020102);
        sy();
        st(32'h0850);
        ck("irq", irq_o, 32'h0);
        w(CPVP_MEAS_IT, 32'h00FAFF9C);
        @(posedge ref_clk_i);
        ck("chg fet", chg_fet_o, 32'h1);
        w(CPVP_MEAS_IT, 32'h00FA0000);
        w(CPVP_MEAS_PACK, 32'h3E80);
        sy();
        st(32'h0C00);
        w(CPVP_IRQ_MASK, 32'h3F);
        w(CPVP_MEAS_CELL, 32'h08980DAC);
        sy();
        st(32'h0C04);
        sy();
        st(32'h17A0);
        ck("dsg path", dsg_on, 32'h0);
        ck("zv fet", zero_volt_charge_fet_o, 32'h1);
        xf(1'h0, CPVP_REQ, 32'h0);
        ck("req", rd[15:0], 32'h64);
        w(CPVP_MEAS_IT, 32'h00FA0064);
        st(32'h1FA0);
        w(CPVP_MEAS_CELL, 32'h0BB70DAC);
        sy();
        st(32'h1FA0);
        w(CPVP_MEAS_CELL, 32'h0BB80DAC);
        sy();
        st(32'h0D00);
        w(CPVP_CTRL, 32'hA);
        st(32'h0C00);
        give_verdict();
    end
endmodule : cpvp_top_bench
